// [hw/iks_consts.vh]
// Constants for the increment-and-skip decode and execute block.
// Assumes an 8-bit data path and 16-bit instruction words from fetch.
// Operation
// - Opcode 001111 decodes increment, skip on zero
// - Opcode 010010 decodes increment, skip on nonzero
// - Add one, write, skip when zero (001111) or nonzero (010010)
// - Destination bit 0 working reg, 1 file
// - Access bit 0, extended, address<=95 uses indexing
// - File address is 8 bits, 0 to 255
// - Access bit 0 access bank, 1 bank select
`ifndef IKS_CONSTS_VH
`define IKS_CONSTS_VH
// Opcode fields
`define IKS_OP_HI 15
`define IKS_OP_LO 10
`define IKS_OP_ZERO 6'h0F
`define IKS_OP_NONZERO 6'h12
`define IKS_DEST_BIT 9
`define IKS_ACCESS_BIT 8
`define IKS_ADDR_HI 7
`define IKS_ADDR_LO 0
// Indexed literal offset limit
`define IKS_INDEX_LIMIT 8'h5F
// Access bank split: low 96 bytes below 60h, rest in top bank
`define IKS_ACCESS_SPLIT 8'h60
`define IKS_ACCESS_TOP_BANK 4'hF
// Reset values and the increment step
`define IKS_ZERO8 8'h00
`define IKS_ZERO12 12'h000
`define IKS_ONE8 8'h01
// Q phase counter
`define IKS_Q1 2'h0
`define IKS_Q2 2'h1
`define IKS_Q3 2'h2
`define IKS_Q4 2'h3
`endif

// [hw/iks_decode.v]
// Opcode decoder for the two increment-and-skip instructions.
// Assumes a stable 16-bit opcode for the whole instruction cycle.
`timescale 1ns/1ps
`default_nettype none
`include "iks_consts.vh"
module iks_decode
(
    // Opcode in
    input wire [15:0] opcode,
    // Decoded fields
    output wire is_zero_skip,
    output wire is_nonzero_skip,
    output wire dest_file,
    output wire use_bank_select,
    output wire [7:0] file_addr
);
    // Upper six bits pick the instruction
    assign is_zero_skip =
        (opcode[`IKS_OP_HI:`IKS_OP_LO] == `IKS_OP_ZERO);
    assign is_nonzero_skip =
        (opcode[`IKS_OP_HI:`IKS_OP_LO] == `IKS_OP_NONZERO);
    // Operand fields
    assign dest_file = opcode[`IKS_DEST_BIT];
    assign use_bank_select = opcode[`IKS_ACCESS_BIT];
    assign file_addr = opcode[`IKS_ADDR_HI:`IKS_ADDR_LO];
endmodule // iks_decode
`default_nettype wire

// [hw/iks_core.v]
// Execute stage for increment-and-skip instructions, four Q phases.
// Assumes data memory answers reads combinationally in the same clock
// and that fetch tells whether the next word is a two-word instruction.
`timescale 1ns/1ps
`default_nettype none
`include "iks_consts.vh"
module iks_core
(
    // Clock and reset
    input wire clock,
    input wire resetn,
    // Fetch side
    input wire [15:0] opcode,
    input wire opcode_valid,
    input wire next_is_two_word,
    // Core state
    input wire [3:0] bank_select_register,
    input wire [11:0] index_base,
    input wire extended_enable,
    // Data memory
    input wire [7:0] mem_rdata,
    output reg [11:0] mem_addr,
    output reg mem_read,
    output reg mem_write,
    output reg [7:0] mem_wdata,
    // Working register write
    output reg w_write,
    output reg [7:0] w_wdata,
    // Pipeline control
    output reg busy,
    output reg flush_next,
    output reg nop_cycle,
    output reg status_write
);
    // One instruction cycle spans four clocks, one per Q phase.
    // Q1 takes the opcode, Q2 reads the file register and forms the sum,
    // Q3 waits, and Q4 writes the chosen destination.
    // Every output is a flip-flop, so results trail the phase by a clock.
    // A skip keeps busy high through the discarded words,
    // which lets fetch stall without its own counter.
    // Status flags are never written by these two instructions.
    // New opcodes are ignored while busy is high.
    // States
    localparam ST_IDLE = 2'h0;
    localparam ST_EXEC = 2'h1;
    localparam ST_SKIP = 2'h2;
    // Decoded fields
    wire is_zero_skip;
    wire is_nonzero_skip;
    wire dest_file;
    wire use_bank_select;
    wire [7:0] file_addr;
    reg [1:0] state; // Main state
    reg [1:0] phase; // Q1..Q4
    reg [1:0] skip_left; // Skipped cycles remaining
    reg [7:0] sum; // Incremented value
    reg opc_zero; // Latched kind
    reg opc_dest; // Latched destination
    reg [11:0] next_addr; // Formed operand address
    wire [7:0] next_sum;
    wire hit;
    iks_decode u_dec
    (
        .opcode(opcode),
        .is_zero_skip(is_zero_skip),
        .is_nonzero_skip(is_nonzero_skip),
        .dest_file(dest_file),
        .use_bank_select(use_bank_select),
        .file_addr(file_addr)
    );
    // Only the two increment-and-skip opcodes start a cycle.
    // Any other opcode leaves every output untouched.
    // The decode is purely combinational, so the opcode
    // only needs to stand at the taking edge.
    assign hit = opcode_valid & (is_zero_skip | is_nonzero_skip);
    // 8-bit wrap is intended: FFh + 1 gives zero
    assign next_sum = mem_rdata + `IKS_ONE8;
    // Operand address forming
    // Priority: bank select first, then indexed literal offset,
    // then the low and top parts of the access bank.
    // Indexing wins over the access bank only for low addresses;
    // the sum wraps within the 12-bit data space by design.
    // Every path assigns the address, so no latch is inferred.
    always @*
    begin
        if (use_bank_select)
        begin
            next_addr = {bank_select_register, file_addr};
        end
        else if (extended_enable && file_addr <= `IKS_INDEX_LIMIT)
        begin
            next_addr = index_base + {4'h0, file_addr};
        end
        else if (file_addr < `IKS_ACCESS_SPLIT)
        begin
            next_addr = {4'h0, file_addr};
        end
        else
        begin
            next_addr = {`IKS_ACCESS_TOP_BANK, file_addr};
        end
    end
    // Sequencer, one instruction cycle is four clocks
    always @(posedge clock)
    begin
        if (!resetn)
        begin
            // Reset clears every output so that the pipeline
            // sees no stray write or flush after release.
            // Only constants are loaded here.
            state <= ST_IDLE;
            phase <= `IKS_Q1;
            skip_left <= 2'h0;
            sum <= `IKS_ZERO8;
            opc_zero <= 1'b0;
            opc_dest <= 1'b0;
            mem_addr <= `IKS_ZERO12;
            mem_read <= 1'b0;
            mem_write <= 1'b0;
            mem_wdata <= `IKS_ZERO8;
            w_write <= 1'b0;
            w_wdata <= `IKS_ZERO8;
            busy <= 1'b0;
            flush_next <= 1'b0;
            nop_cycle <= 1'b0;
            status_write <= 1'b0;
        end
        else
        begin
            // Strobes are one clock wide
            mem_read <= 1'b0;
            mem_write <= 1'b0;
            w_write <= 1'b0;
            flush_next <= 1'b0;
            status_write <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    // Waiting for a matching opcode
                    // The read is issued here so the data memory
                    // answers during the next phase.
                    nop_cycle <= 1'b0;
                    phase <= `IKS_Q1;
                    if (hit)
                    begin
                        // Q1 decode: latch fields
                        opc_zero <= is_zero_skip;
                        opc_dest <= dest_file;
                        mem_addr <= next_addr;
                        mem_read <= 1'b1;
                        busy <= 1'b1;
                        phase <= `IKS_Q2;
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    // Phase counter wraps back to Q1 after Q4,
                    // which the skip state relies on.
                    // The 8-bit sum decides the skip at Q4.
                    phase <= phase + 2'h1;
                    if (phase == `IKS_Q2)
                    begin
                        // Q2 read
                        sum <= next_sum;
                    end
                    else if (phase == `IKS_Q4)
                    begin
                        // Q4 write destination
                        if (opc_dest)
                        begin
                            mem_write <= 1'b1;
                            mem_wdata <= sum;
                        end
                        else
                        begin
                            w_write <= 1'b1;
                            w_wdata <= sum;
                        end
                        if ((sum == `IKS_ZERO8) == opc_zero)
                        begin
                            // Skip: next word becomes a no-operation
                            flush_next <= 1'b1;
                            nop_cycle <= 1'b1;
                            skip_left <= next_is_two_word ? 2'h2 : 2'h1;
                            state <= ST_SKIP;
                        end
                        else
                        begin
                            busy <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_SKIP:
                begin
                    // One or two discarded words, four clocks each
                    // The word count was fixed at the write edge,
                    // so a late change from fetch cannot stretch it.
                    // Each skipped cycle runs four idle phases
                    phase <= phase + 2'h1;
                    if (phase == `IKS_Q4)
                    begin
                        skip_left <= skip_left - 2'h1;
                        if (skip_left == 2'h1)
                        begin
                            busy <= 1'b0;
                            nop_cycle <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    // Unused code: recover to idle
                    // rather than hang with busy stuck high.
                    state <= ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end
endmodule // iks_core
`default_nettype wire

// [verification/iks_chk.sv]
// Checker for the increment-and-skip execute block.
// Bound to iks_core; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module iks_chk (
    // Inputs
    input wire clock,
    input wire resetn,
    input wire [15:0] opcode,
    input wire opcode_valid,
    input wire [3:0] bank_select_register,
    input wire [11:0] index_base,
    input wire extended_enable,
    input wire [7:0] mem_rdata,
    // Outputs
    input wire [11:0] mem_addr,
    input wire mem_read,
    input wire mem_write,
    input wire [7:0] mem_wdata,
    input wire w_write,
    input wire [7:0] w_wdata,
    input wire busy,
    input wire flush_next,
    input wire nop_cycle,
    input wire status_write
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire [7:0] f = opcode[7:0];
    wire zop = opcode[15:10] == 6'h0F;
    wire take = !busy && opcode_valid && (zop || opcode[15:10] == 6'h12);
    // Operand address; indexing wins over the access bank
    wire [11:0] ea = opcode[8] ? {bank_select_register, f} :
        (extended_enable && f <= 8'h5F) ? index_base + {4'h0, f} :
        {f < 8'h60 ? 4'h0 : 4'hF, f};
    wire wr = mem_write || w_write;
    wire [7:0] wd = mem_write ? mem_wdata : w_wdata;
    reg zt;
    // Kind of the running instruction
    always @(posedge clock)
        if (take)
            zt <= zop;
    sequence s_take; take; endsequence
    sequence s_nop; nop_cycle [*4]; endsequence
    property p_rd; s_take |=> mem_read && busy && mem_addr == $past(ea);
    endproperty
    a_rd: assert property (p_rd) else $error("bad read");
    property p_drop; !busy && opcode_valid && !take |=> !busy; endproperty
    a_drop: assert property (p_drop) else $error("bad take");
    property p_dst; s_take |=> ##3 wr && mem_write == $past(opcode[9], 4);
    endproperty
    a_dst: assert property (p_dst) else $error("bad dest");
    property p_sum; logic [7:0] v;
        (mem_read, v = mem_rdata + 8'h01) |-> ##3 wr && wd == v; endproperty
    a_sum: assert property (p_sum) else $error("bad sum");
    property p_skip; wr |-> flush_next == (zt ? wd == 8'h00 : wd != 8'h00);
    endproperty
    a_skip: assert property (p_skip) else $error("bad skip");
    property p_nop; flush_next |-> s_nop ##[1:6] !busy; endproperty
    a_nop: assert property (p_nop) else $error("bad nops");
    property p_one; wr && !flush_next |-> !busy && !nop_cycle; endproperty
    a_one: assert property (p_one) else $error("bad end");
    property p_flag; status_write == 1'b0; endproperty
    a_flag: assert property (p_flag) else $error("flags hit");
endmodule // iks_chk
`default_nettype wire

// [verification/iks_mem.sv]
// Data memory model; reads answer in the same clock.
// The bench preloads cells before each instruction.
`timescale 1ns/1ps
`default_nettype none
module iks_mem (
    // Memory port
    input wire logic clock,
    input wire logic [11:0] mem_addr,
    input wire logic mem_write,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:4095];
    assign mem_rdata = mem[mem_addr];
    // Store the written sum
    always @(posedge clock)
        if (mem_write)
            mem[mem_addr] <= mem_wdata;
endmodule // iks_mem
`default_nettype wire

// [verification/tb_top.sv]
// Bench: random increment-and-skip runs against a memory model.
// Needs iks_core, iks_mem and iks_chk compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
$display("wrong value at %0t: result", $time); end end
module tb_top;
    logic clock = 0, resetn = 0, opcode_valid = 0, two = 0, ext = 0;
    logic [15:0] opcode = 16'h0000;
    logic [3:0] bank_sel = 4'h0;
    logic [11:0] ib = 12'h000, mem_addr;
    logic [7:0] f, s, mem_rdata, mem_wdata, w_wdata;
    logic mem_read, mem_write, w_write, busy, flush_next, nop_cycle, sw;
    int num_errors = 0, compares = 0, seed = 32'h132E0004, n;
    logic [9:0] q[$];
    always #4 clock = ~clock;
    iks_core DUT (.clock, .resetn, .opcode, .opcode_valid,
        .next_is_two_word(two), .bank_select_register(bank_sel),
        .index_base(ib), .extended_enable(ext), .mem_rdata, .mem_addr,
        .mem_read, .mem_write, .mem_wdata, .w_write, .w_wdata, .busy,
        .flush_next, .nop_cycle, .status_write(sw));
    iks_mem MEM (.clock, .mem_addr, .mem_write, .mem_wdata, .mem_rdata);
    task final_report;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Oldest note against each write pulse
    always @(negedge clock)
        if (mem_write || w_write)
            `CHK({mem_write, mem_write ? mem_wdata : w_wdata, flush_next}, q.pop_front())
    // Random runs; every third value wraps to zero
    initial
    begin
        repeat (12) @(negedge clock);
        resetn = 1;
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clock);
            bank_sel = $random(seed);
            ib = $random(seed);
            {ext, two} = $random(seed);
            f = i < 8 ? 8'h5F + i[0] : $random(seed);
            s = i % 3 ? $random(seed) : 8'hFF;
            opcode = {i[0] ? 6'h12 : 6'h0F, i[2:1], f};
            MEM.mem[opcode[8] ? {bank_sel, f} : (ext && f <= 8'h5F) ?
                ib + {4'h0, f} : {f < 8'h60 ? 4'h0 : 4'hF, f}] = s;
            s = s + 8'h01;
            q.push_back({opcode[9], s, i[0] ? s != 0 : s == 0});
            opcode_valid = 1;
            @(negedge clock);
            opcode_valid = 0;
            for (n = 0; n < 20 && busy !== 1'b0; n++) @(negedge clock);
            if (n == 20)
            begin
                num_errors++;
                final_report;
            end
        end
        opcode = 16'hFFFF;
        opcode_valid = 1;
        repeat (3) @(negedge clock);
        final_report;
    end
endmodule // tb_top
bind iks_core iks_chk u_chk (.clock, .resetn, .opcode, .opcode_valid,
    .bank_select_register, .index_base, .extended_enable, .mem_rdata,
    .mem_addr, .mem_read, .mem_write, .mem_wdata, .w_write, .w_wdata,
    .busy, .flush_next, .nop_cycle, .status_write);
`default_nettype wire
